//--- hw/multifunction_timer_watchdog.v
// Multifunction timer: prescaled counter chain, overflow and periodic
// interrupts, and a watchdog clocked by the selected periodic tap.
// Assumes a classic Wishbone master on clk_i and a CPU that pulses
// stop_exec_i on a stop instruction and wake_i on wakeup.
// Option straps are static levels from outside the clock domain;
// every other input is driven from logic on clk_i.
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps
`include "timer_wdt_regs.vh"

module multifunction_timer_watchdog #(
  parameter POR_CYCLES = `POR_CYCLES
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [9:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output wire [31:0] dat_o,
  output wire        ack_o,
  input  wire [7:0]  prog_mem_byte_i,
  input  wire        watchdog_option_enable_i,
  input  wire        stop_to_halt_option_i,
  input  wire        stop_exec_i,
  input  wire        wake_i,
  output wire        overflow_irq_o,
  output wire        periodic_irq_o,
  output wire        ctrl_reset_o,
  output wire        stopped_o
);

  // -------------------------------------------------------------
  // Declarations
  // -------------------------------------------------------------
  // Prescaler plus core stages
  localparam CHAIN_W = `PRESCALE_BITS + `CHAIN_STAGES;

  // Counter, watchdog and bus decode nets
  wire [CHAIN_W-1:0]     chain_count;
  wire                   chain_full;
  wire [`WDT_STAGES-1:0] wdt_count;
  wire [1:0]             options;
  wire                   wdt_enable;
  wire                   halt_on_stop;
  wire                   timer_run;
  wire                   core_reset;
  wire                   bus_req;
  wire                   wr_stb;
  wire                   wr_tsc;
  wire                   wr_wdc;
  wire                   ovf_event;
  wire                   per_event;
  wire                   wdt_clear;
  wire                   wdt_bite;
  wire [7:0]             tsc_read;

  // State registers and their next values
  reg                    por_active_reg;
  reg  [`POR_CNT_BITS-1:0] por_cnt_reg;
  reg                    por_release_reg;
  reg                    wdt_bite_reg;
  reg                    stopped_reg;
  reg                    ovf_flag_reg;
  reg                    ovf_flag_next;
  reg                    per_flag_reg;
  reg                    per_flag_next;
  reg                    ovf_ie_reg;
  reg                    per_ie_reg;
  reg  [1:0]             rate_reg;
  reg                    per_tap;
  reg                    ack_reg;
  reg  [31:0]            dat_reg;
  reg  [31:0]            dat_next;

  // -------------------------------------------------------------
  // Option inputs
  // -------------------------------------------------------------
  // Option straps come from outside and are synchronised
  // Nothing reads the straps before both flops have seen them
  sync_ff #(
    .WIDTH (2)
  ) u_opt_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({stop_to_halt_option_i, watchdog_option_enable_i}),
    .q_o   (options)
  );

  assign wdt_enable   = options[0];
  assign halt_on_stop = options[1];

  // -------------------------------------------------------------
  // Power-on delay
  // -------------------------------------------------------------
  // Hold the controller in reset for POR_CYCLES, then release
  // The chain keeps counting through the delay; the release pulse
  // clears it once more so software starts from a fresh count
  always @(posedge clk_i) begin
    if (rst_i) begin
      por_active_reg  <= 1'b1;
      por_cnt_reg     <= {`POR_CNT_BITS{1'b0}};
      por_release_reg <= 1'b0;
    end else if (por_active_reg) begin
      if (por_cnt_reg == POR_CYCLES[`POR_CNT_BITS-1:0] - 1'b1) begin
        por_active_reg  <= 1'b0;
        por_release_reg <= 1'b1;
      end else begin
        por_cnt_reg <= por_cnt_reg + 1'b1;
      end
    end else begin
      por_release_reg <= 1'b0;
    end
  end

  // Registers are held while power-on or watchdog reset is active; the
  // release cycle is held too, as the chain only clears at its end and
  // an old count there must not set a flag
  assign core_reset   = rst_i | por_active_reg | por_release_reg | wdt_bite_reg;
  assign ctrl_reset_o = por_active_reg | wdt_bite_reg;

  // -------------------------------------------------------------
  // Stop handling
  // -------------------------------------------------------------
  // Stop freezes the timer unless the option turns it into halt
  // Wake wins over a stop in the same cycle, so the part keeps running
  always @(posedge clk_i) begin
    if (core_reset) begin
      stopped_reg <= 1'b0;
    end else if (wake_i) begin
      stopped_reg <= 1'b0;
    end else if (stop_exec_i && !halt_on_stop) begin
      stopped_reg <= 1'b1;
    end
  end

  assign stopped_o = stopped_reg;
  // Halt and wait leave the timer clock running
  // so the chain, the flags and the watchdog all keep going there
  assign timer_run = !stopped_reg;

  // -------------------------------------------------------------
  // Counter chain
  // -------------------------------------------------------------
  // Two prescale stages then fifteen counting stages
  // Bits [1:0] divide by four, bits [9:2] are the readable count
  stage_counter #(
    .WIDTH (CHAIN_W)
  ) u_chain (
    .clk_i   (clk_i),
    .clr_i   (rst_i | por_release_reg),
    .en_i    (timer_run),
    .count_o (chain_count),
    .full_o  (chain_full)
  );

  // Readable count moves every four clocks; wrap every 1024
  // The event is gated by run so a frozen chain sets nothing
  assign ovf_event = timer_run & (&chain_count[`COUNT_LSB+`COUNT_BITS-1:0]);

  // Periodic tap fires as the selected low stages wrap
  // A rate change can fake or swallow one tick; software clears the
  // watchdog first so that the odd tick cannot cause a timeout
  always @* begin
    case (rate_reg)
      2'b00:   per_tap = &chain_count[`TAP_BASE_BIT:0];
      2'b01:   per_tap = &chain_count[`TAP_BASE_BIT+1:0];
      2'b10:   per_tap = &chain_count[`TAP_BASE_BIT+2:0];
      2'b11:   per_tap = chain_full;
      default: per_tap = 1'b0;
    endcase
  end

  // A stopped chain raises no periodic tick either
  assign per_event = timer_run & per_tap;

  // -------------------------------------------------------------
  // Watchdog
  // -------------------------------------------------------------
  // Any reset, a clear write, stop or a missing option empties it
  assign wdt_clear = core_reset | wr_wdc | stopped_reg | !wdt_enable;

  // Four stages counting periodic ticks in run, wait and halt
  stage_counter #(
    .WIDTH (`WDT_STAGES)
  ) u_wdt (
    .clk_i   (clk_i),
    .clr_i   (wdt_clear),
    .en_i    (per_event & wdt_enable),
    .count_o (wdt_count),
    .full_o  ()
  );

  // Ninth tick after clear: at least eight whole intervals
  // and at most nine, as the clear may land just after a tick
  assign wdt_bite = per_event & wdt_enable & !wdt_clear
                    & (wdt_count == `WDT_TIMEOUT_TICKS);

  // One-cycle controller reset on timeout
  // Registered so that the reset pulse is free of glitches
  always @(posedge clk_i) begin
    if (rst_i) begin
      wdt_bite_reg <= 1'b0;
    end else begin
      wdt_bite_reg <= wdt_bite;
    end
  end

  // -------------------------------------------------------------
  // Wishbone slave
  // -------------------------------------------------------------
  // Requests are taken only while ack is low, so a held request is
  // answered once; only the low byte lane carries register data
  assign bus_req    = cyc_i & stb_i & !ack_reg;
  assign wr_stb     = bus_req & we_i & sel_i[0];
  assign wr_tsc     = wr_stb & (adr_i == `TSC_ADDR);
  assign wr_wdc     = wr_stb & (adr_i == `WDC_ADDR) & !dat_i[`WDC_CLEAR_BIT];

  // Ack one cycle after the request, drop the cycle after
  // One wait state buys a registered ack and registered read data
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req;
    end
  end

  assign ack_o = ack_reg;

  // -------------------------------------------------------------
  // Control bits
  // -------------------------------------------------------------
  // Enables and rate select written through the status register
  // The flag-clear bits are strobes only and keep no state
  always @(posedge clk_i) begin
    if (core_reset) begin
      ovf_ie_reg <= `IE_RESET;
      per_ie_reg <= `IE_RESET;
      rate_reg   <= `RATE_RESET;
    end else if (wr_tsc) begin
      ovf_ie_reg <= dat_i[`TSC_OVF_IE_BIT];
      per_ie_reg <= dat_i[`TSC_PER_IE_BIT];
      rate_reg   <= dat_i[`TSC_RATE_HI_BIT:`TSC_RATE_LO_BIT];
    end
  end

  // -------------------------------------------------------------
  // Interrupt flags
  // -------------------------------------------------------------
  // Flags set by events, cleared by clear bits; setting wins
  // so a tick that meets a clear write in one cycle is not lost
  always @* begin
    ovf_flag_next = ovf_flag_reg;
    per_flag_next = per_flag_reg;
    if (wr_tsc && dat_i[`TSC_OVF_CLR_BIT]) begin
      ovf_flag_next = 1'b0;
    end
    if (wr_tsc && dat_i[`TSC_PER_CLR_BIT]) begin
      per_flag_next = 1'b0;
    end
    if (ovf_event) begin
      ovf_flag_next = 1'b1;
    end
    if (per_event) begin
      per_flag_next = 1'b1;
    end
  end

  always @(posedge clk_i) begin
    if (core_reset) begin
      ovf_flag_reg <= 1'b0;
      per_flag_reg <= 1'b0;
    end else begin
      ovf_flag_reg <= ovf_flag_next;
      per_flag_reg <= per_flag_next;
    end
  end

  // Level requests while flag and enable are both set
  assign overflow_irq_o = ovf_flag_reg & ovf_ie_reg;
  assign periodic_irq_o = per_flag_reg & per_ie_reg;

  // -------------------------------------------------------------
  // Read data
  // -------------------------------------------------------------
  // Clear bits always read as zero
  assign tsc_read = {ovf_flag_reg, per_flag_reg, ovf_ie_reg, per_ie_reg,
                     2'b00, rate_reg};

  // Read mux; unmapped addresses read zero
  // Data is sampled at the taking edge and stands in the ack cycle
  always @* begin
    dat_next = 32'h0000_0000;
    if (bus_req && !we_i) begin
      case (adr_i)
        `TSC_ADDR: dat_next = {24'h00_0000, tsc_read};
        `TCV_ADDR: dat_next = {24'h00_0000,
                               chain_count[`COUNT_LSB+`COUNT_BITS-1:`COUNT_LSB]};
        `WDC_ADDR: dat_next = {24'h00_0000, prog_mem_byte_i};
        default:   dat_next = 32'h0000_0000;
      endcase
    end
  end

  // Read data register, zero outside the ack cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= 32'h0000_0000;
    end else begin
      dat_reg <= dat_next;
    end
  end

  assign dat_o = dat_reg;

endmodule // multifunction_timer_watchdog

//--- inc/timer_wdt_regs.vh
// Constants for the multifunction timer and watchdog block.
// Included by the design files; holds definitions only.
`ifndef TIMER_WDT_REGS_VH
`define TIMER_WDT_REGS_VH

// ---------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------
`define TSC_ADDR          10'h008
`define TCV_ADDR          10'h00C
`define WDC_ADDR          10'h3F0

// ---------------------------------------------------------------
// Status/control field positions
// ---------------------------------------------------------------
`define TSC_OVF_BIT       7
`define TSC_PER_BIT       6
`define TSC_OVF_IE_BIT    5
`define TSC_PER_IE_BIT    4
`define TSC_OVF_CLR_BIT   3
`define TSC_PER_CLR_BIT   2
`define TSC_RATE_HI_BIT   1
`define TSC_RATE_LO_BIT   0
`define WDC_CLEAR_BIT     0

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RATE_RESET        2'b11
`define IE_RESET          1'b0

// ---------------------------------------------------------------
// Counter geometry and timing counts
// ---------------------------------------------------------------
`define PRESCALE_BITS     2
`define CHAIN_STAGES      15
`define COUNT_LSB         2
`define COUNT_BITS        8
`define TAP_BASE_BIT      13
`define WDT_STAGES        4
`define WDT_TIMEOUT_TICKS 4'h8
`define POR_CYCLES        4064
`define POR_CNT_BITS      12

`endif

//--- hw/sync_ff.v
// Two-flop synchroniser for a group of static option levels.
// Assumes inputs are slow levels from outside the clock domain.
`timescale 1ns/1ps

module sync_ff #(
  parameter WIDTH = 1
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire [WIDTH-1:0] d_i,
  output wire [WIDTH-1:0] q_o
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  // First stage feeds only the second stage
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
    end
  end

  assign q_o = sync_reg;

endmodule // sync_ff

//--- hw/stage_counter.v
// Parameterised binary counter with clear, enable and all-ones flag.
// Assumes clear and enable come from logic on the same clock.
`timescale 1ns/1ps

module stage_counter #(
  parameter WIDTH = 4
) (
  input  wire             clk_i,
  input  wire             clr_i,
  input  wire             en_i,
  output wire [WIDTH-1:0] count_o,
  output wire             full_o
);

  reg [WIDTH-1:0] count_reg;

  // Clear has priority over counting
  always @(posedge clk_i) begin
    if (clr_i) begin
      count_reg <= {WIDTH{1'b0}};
    end else if (en_i) begin
      count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  assign count_o = count_reg;
  assign full_o  = &count_reg;

endmodule // stage_counter

//--- verif/timer_wdt_properties.sv
// Checker for the timer and watchdog block, bound to its top ports.
// Assumes the block's header constants and a classic Wishbone master.
`timescale 1ns/1ps
`include "timer_wdt_regs.vh"

module timer_wdt_properties (
  input wire        clk_i,
  input wire        rst_i,
  input wire        cyc_i,
  input wire        stb_i,
  input wire        we_i,
  input wire [9:0]  adr_i,
  input wire [3:0]  sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire        ack_o,
  input wire [7:0]  prog_mem_byte_i,
  input wire        stop_to_halt_option_i,
  input wire        stop_exec_i,
  input wire        wake_i,
  input wire        overflow_irq_o,
  input wire        periodic_irq_o,
  input wire        ctrl_reset_o,
  input wire        stopped_o
);
  // -----------------
  // Decoded requests
  // -----------------
  wire tk   = cyc_i & stb_i & ~ack_o;
  wire rd_c = tk & ~we_i & (adr_i == `TSC_ADDR);
  wire wr_c = tk & we_i & sel_i[0] & (adr_i == `TSC_ADDR);
  wire rd_w = tk & ~we_i & (adr_i == `WDC_ADDR);
  wire rd_u = rd_c | rd_w | (adr_i == `TCV_ADDR) | we_i;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // -----------------
  // Properties
  // -----------------
  AST_ACK_NEXT: assert property (tk |=> ack_o) else $error("ack late");
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("ack held");
  AST_UPPER_ZERO: assert property (ack_o |-> dat_o[31:8] == 24'h00_0000)
    else $error("upper data set");
  AST_CLR_READ_ZERO: assert property (rd_c |=> dat_o[3:2] == 2'b00)
    else $error("clear bits read one");
  AST_WDC_READ: assert property (rd_w |=> dat_o[7:0] == $past(prog_mem_byte_i))
    else $error("clear location read wrong");
  AST_UNMAPPED_ZERO: assert property (tk && !rd_u |=> dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_OVF_HOLD: assert property (overflow_irq_o && !wr_c && !ctrl_reset_o
    |=> overflow_irq_o || ctrl_reset_o) else $error("overflow request dropped");
  AST_PER_HOLD: assert property (periodic_irq_o && !wr_c && !ctrl_reset_o
    |=> periodic_irq_o || ctrl_reset_o) else $error("periodic request dropped");
  AST_OVF_CLEAR: assert property (wr_c && dat_i[3] |=> !overflow_irq_o)
    else $error("overflow flag not cleared");
  AST_PER_CLEAR: assert property (wr_c && dat_i[2] |=> !periodic_irq_o)
    else $error("periodic flag not cleared");
  AST_OVF_GATE: assert property (wr_c && !dat_i[5] |=> !overflow_irq_o)
    else $error("overflow request while disabled");
  AST_STOP_ENTER: assert property (!stop_to_halt_option_i [*4] ##0
    (stop_exec_i && !ctrl_reset_o) |=> stopped_o) else $error("stop ignored");
  AST_HALT: assert property (stop_to_halt_option_i [*4] ##0
    (stop_exec_i && !stopped_o) |=> !stopped_o) else $error("halt stopped");
  AST_WAKE: assert property (stopped_o && wake_i |=> !stopped_o)
    else $error("wake ignored");
endmodule // timer_wdt_properties

bind multifunction_timer_watchdog timer_wdt_properties u_props (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .prog_mem_byte_i(prog_mem_byte_i), .stop_to_halt_option_i(stop_to_halt_option_i),
  .stop_exec_i(stop_exec_i), .wake_i(wake_i), .overflow_irq_o(overflow_irq_o),
  .periodic_irq_o(periodic_irq_o), .ctrl_reset_o(ctrl_reset_o), .stopped_o(stopped_o));

//--- verif/testbench.sv
// Self-checking bench for the timer and watchdog block.
// Assumes a short power-on delay through the POR_CYCLES parameter.
`timescale 1ns/1ps
`include "timer_wdt_regs.vh"

module testbench;
  localparam POR = 16;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [9:0]  adr = 10'h000;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000;
  logic [7:0]  pm = 8'h00;
  logic        sth = 1'b0;
  logic        stp = 1'b0;
  logic        wk = 1'b0;
  logic        wde = 1'b1;
  wire  [31:0] dat_o;
  wire         ack_o;
  wire         ovf;
  wire         per;
  wire         crst;
  wire         stopped;
  int          mismatches = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          t0;
  int          k;
  logic [31:0] rd;
  logic [7:0]  c0;

  multifunction_timer_watchdog #(.POR_CYCLES(POR)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .prog_mem_byte_i(pm), .watchdog_option_enable_i(wde),
    .stop_to_halt_option_i(sth), .stop_exec_i(stp), .wake_i(wk),
    .overflow_irq_o(ovf), .periodic_irq_o(per), .ctrl_reset_o(crst),
    .stopped_o(stopped));

  // ----------------
  // Clock and timeout
  // ----------------
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches = mismatches + 1;
      final_report();
    end
  end

  // ----------------
  // Tasks
  // ----------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Single classic cycle; read data taken at the ack edge
  task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
    {cyc, stb, we} <= {2'b11, w};
    adr <= a;
    sel <= 4'h1;
    dat <= {24'h00_0000, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    {cyc, stb} <= 2'b00;
    @(posedge clk_i);
  endtask

  task automatic wait_hi(input logic p);
    do @(posedge clk_i); while ((p ? per : ovf) !== 1'b1);
  endtask

  task automatic final_report();
    if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------
  // Main sequence
  // ----------------
  initial begin
    void'($urandom(32'h8809));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (crst !== 1'b0 && k < 100);
    check(k >= POR && k <= POR + 2, 1);
    wb(0, `TSC_ADDR, 8'h00);
    check(rd, 32'h0000_0003);
    wb(1, `TSC_ADDR, 8'hFF);
    wb(0, `TSC_ADDR, 8'h00);
    check(rd, 32'h0000_0033);
    repeat (3) begin
      wb(0, 10'h010 + 10'($urandom_range(0, 900)), 8'h00);
      check(rd, 32'h0000_0000);
      pm <= 8'($urandom);
      wb(0, `WDC_ADDR, 8'h00);
      check(rd, {24'h00_0000, pm});
      wb(1, `WDC_ADDR, 8'h00);
      k = $urandom;
      wb(1, `TSC_ADDR, 8'(k));
      wb(0, `TSC_ADDR, 8'h00);
      check(rd[5:0], {k[5:4], 2'b00, k[1:0]});
    end
    // Count rate over a random span of whole prescale periods
    wb(0, `TCV_ADDR, 8'h00);
    c0 = rd[7:0];
    k = $urandom_range(1, 60);
    // The read cycle itself spends three clocks of the span
    repeat (4 * k - 3) @(posedge clk_i);
    wb(0, `TCV_ADDR, 8'h00);
    check(rd[7:0], 8'(c0 + k));
    // Stop freezes the chain, wake resumes, halt option refuses stop
    stp <= 1'b1;
    @(posedge clk_i);
    stp <= 1'b0;
    repeat (2) @(posedge clk_i);
    check(stopped, 1);
    wb(0, `TCV_ADDR, 8'h00);
    c0 = rd[7:0];
    repeat (40) @(posedge clk_i);
    wb(0, `TCV_ADDR, 8'h00);
    check(rd[7:0], c0);
    wk <= 1'b1;
    @(posedge clk_i);
    wk <= 1'b0;
    repeat (2) @(posedge clk_i);
    check(stopped, 0);
    sth <= 1'b1;
    repeat (5) @(posedge clk_i);
    wb(1, `WDC_ADDR, 8'h00);
    stp <= 1'b1;
    @(posedge clk_i);
    stp <= 1'b0;
    repeat (2) @(posedge clk_i);
    check(stopped, 0);
    sth <= 1'b0;
    // Overflow flag, request level, clear and period
    wb(1, `TSC_ADDR, 8'h2F);
    wait_hi(0);
    t0 = cycles;
    repeat (5) @(posedge clk_i);
    check(ovf, 1);
    wb(0, `TSC_ADDR, 8'h00);
    check(rd[7], 1);
    wb(1, `TSC_ADDR, 8'h2B);
    check(ovf, 0);
    wait_hi(0);
    check(cycles - t0, 1024);
    wb(1, `TSC_ADDR, 8'h03);
    wb(0, `TSC_ADDR, 8'h00);
    check({ovf, rd[7]}, 2'b01);
    // Periodic flag at the fastest rate with the watchdog kept clear
    wb(1, `WDC_ADDR, 8'h00);
    wb(1, `TSC_ADDR, 8'h1C);
    wait_hi(1);
    t0 = cycles;
    wb(1, `WDC_ADDR, 8'hFE);
    wb(1, `TSC_ADDR, 8'h1C);
    check(per, 0);
    wait_hi(1);
    check(cycles - t0, 16384);
    check(crst, 0);
    final_report();
  end
endmodule // testbench
